// file: src/sccds_div_reg.sv
// Purpose: one channel clock divider register and its reference tick
// Assumes: writes come from the register port on the same clock
// Notes: a zero reference divider stops the tick rather than dividing by 0
`timescale 1ns/10ps
module sccds_div_reg (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register write
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  // register contents
  output logic [15:0] regValue,
  output logic [3:0] sensorInDiv,
  output logic [9:0] refClkDiv,
  // derived state
  output logic sensorCfgBad,
  output logic refTick
);
  logic [9:0] refCnt;
  logic cntWrap;

  // whole register, reserved bits stored as written
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      regValue <= sccds_pkg::DIV_RESET;
    else if (wrEn)
      regValue <= wrData;
  end

  // field copies for the conversion core
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sensorInDiv <= sccds_pkg::DIV_RESET[sccds_pkg::SENS_DIV_MSB:
                                          sccds_pkg::SENS_DIV_LSB];
      refClkDiv <= sccds_pkg::DIV_RESET[sccds_pkg::REF_DIV_MSB:
                                        sccds_pkg::REF_DIV_LSB];
      sensorCfgBad <= 1'h1; // reset code 0 is the reserved one
    end
    else if (wrEn)
    begin
      sensorInDiv <= wrData[sccds_pkg::SENS_DIV_MSB:sccds_pkg::SENS_DIV_LSB];
      refClkDiv <= wrData[sccds_pkg::REF_DIV_MSB:sccds_pkg::REF_DIV_LSB];
      // code 0 is reserved, flagged to the core
      sensorCfgBad <= (wrData[sccds_pkg::SENS_DIV_MSB:
                              sccds_pkg::SENS_DIV_LSB] == 4'h0);
    end
  end

  assign cntWrap = ({1'h0, refCnt} + 11'h001) >= {1'h0, refClkDiv};

  // reference divider: one tick every refClkDiv clocks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      refCnt <= 10'h000;
      refTick <= 1'h0;
    end
    else
    begin
      // a write restarts the count so no short period leaks out
      if (wrEn || refClkDiv == 10'h000 || cntWrap)
        refCnt <= 10'h000;
      else
        refCnt <= refCnt + 10'h001;
      refTick <= !wrEn && refClkDiv != 10'h000 && cntWrap;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_fin_reserved: assert property (
    sensorCfgBad == (sensorInDiv == 4'h0))
    else $error("sensor divider reserved flag wrong");
  a_ref_zero_stop: assert property (
    refTick |-> refClkDiv != 10'h000 && !$past(wrEn))
    else $error("reference tick with reserved divider");
  a_ref_period_two: assert property (
    refTick && refClkDiv == 10'h002 && !wrEn ##1 !wrEn |=> refTick)
    else $error("divide by two tick missing");
  c_tick_seen: cover property (refTick && refClkDiv > 10'h001);
endmodule : sccds_div_reg

// file: src/sccds_pkg.sv
// Purpose: shared constants of the sensor clock divider and status bank
// Assumes: 8-bit register addresses, 16-bit register data
// Notes: divider and error channel reset values and the field positions live here
package sccds_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CH2_DIV = 8'h16;
  localparam logic [7:0] ADDR_CH3_DIV = 8'h17;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_ERR_CFG = 8'h19;
  // channel result registers, one every second address from here
  localparam logic [7:0] ADDR_DATA_BASE = 8'h00;
  localparam int NUM_DIV_CH = 2;
  localparam int FIRST_DIV_CH = 2;
  // divider register fields
  localparam int SENS_DIV_MSB = 15;
  localparam int SENS_DIV_LSB = 12;
  localparam int RSV_MSB = 11;
  localparam int RSV_LSB = 10;
  localparam int REF_DIV_MSB = 9;
  localparam int REF_DIV_LSB = 0;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  // status fields
  localparam int ST_CHAN_MSB = 15;
  localparam int ST_CHAN_LSB = 14;
  localparam int ST_UR_BIT = 13;
  localparam int ST_OR_BIT = 12;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  // error routing enables
  localparam int CFG_UR_IRQ_BIT = 7;
  localparam int CFG_OR_IRQ_BIT = 6;
endpackage : sccds_pkg

// file: src/sccds_regs.sv
// Purpose: clock divider registers of channels 2 and 3 and the error
//   part of the status register, with the interrupt pin
// Assumes: register port driven by the serial interface logic on clk;
//   error events are one-cycle pulses from the conversion core
// Notes: read data is registered, valid the cycle after regRd
`timescale 1ns/10ps
module sccds_regs (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // events from the conversion core
  input wire logic urErr,
  input wire logic orErr,
  input wire logic [1:0] errChannel,
  // divider settings to the core
  output logic [3:0] sensorInDivC2,
  output logic [3:0] sensorInDivC3,
  output logic [9:0] refClkDivC2,
  output logic [9:0] refClkDivC3,
  output logic [1:0] sensorCfgBad,
  output logic [1:0] refTick,
  // status and pin
  output logic [1:0] errorSourceChannel,
  output logic underrangeFlag,
  output logic overrangeFlag,
  output logic interruptOutN
);
  logic [15:0] divValue [sccds_pkg::NUM_DIV_CH];
  logic [3:0] divSens [sccds_pkg::NUM_DIV_CH];
  logic [9:0] divRef [sccds_pkg::NUM_DIV_CH];
  logic underrangeIrqEnable;
  logic overrangeIrqEnable;
  logic errLatched;
  logic statusRead;
  logic latchClear;
  logic urEvent;
  logic orEvent;
  logic errEvent;
  logic [15:0] next_rdData;

  // true when addr is the result register of channel chan
  function automatic logic isDataOf(input logic [7:0] addr,
                                    input logic [1:0] chan);
    isDataOf = addr == sccds_pkg::ADDR_DATA_BASE + {5'h00, chan, 1'h0};
  endfunction : isDataOf

  // one divider register per channel
  genvar gi;
  generate
    for (gi = 0; gi < sccds_pkg::NUM_DIV_CH; gi++)
    begin : g_div
      sccds_div_reg u_div (
        .clk(clk),
        .arst_n(arst_n),
        .wrEn(regWr && regAddr == sccds_pkg::ADDR_CH2_DIV + 8'(gi)),
        .wrData(regWrData),
        .regValue(divValue[gi]),
        .sensorInDiv(divSens[gi]),
        .refClkDiv(divRef[gi]),
        .sensorCfgBad(sensorCfgBad[gi]),
        .refTick(refTick[gi])
      );
    end
  endgenerate

  assign sensorInDivC2 = divSens[0];
  assign sensorInDivC3 = divSens[1];
  assign refClkDivC2 = divRef[0];
  assign refClkDivC3 = divRef[1];

  // routing enables, only bits 7 and 6 are kept here
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      underrangeIrqEnable <= 1'h0;
      overrangeIrqEnable <= 1'h0;
    end
    else if (regWr && regAddr == sccds_pkg::ADDR_ERR_CFG)
    begin
      underrangeIrqEnable <= regWrData[sccds_pkg::CFG_UR_IRQ_BIT];
      overrangeIrqEnable <= regWrData[sccds_pkg::CFG_OR_IRQ_BIT];
    end
  end

  // gated events and clear conditions
  assign urEvent = urErr && underrangeIrqEnable;
  assign orEvent = orErr && overrangeIrqEnable;
  assign errEvent = urEvent || orEvent;
  assign statusRead = regRd && regAddr == sccds_pkg::ADDR_STATUS;
  assign latchClear = statusRead ||
                      (regRd && isDataOf(regAddr, errorSourceChannel));

  // sticky error flags; a new event wins over the read that clears
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      underrangeFlag <= 1'h0;
      overrangeFlag <= 1'h0;
    end
    else
    begin
      if (urEvent)
        underrangeFlag <= 1'h1;
      else if (statusRead)
        underrangeFlag <= 1'h0;
      if (orEvent)
        overrangeFlag <= 1'h1;
      else if (statusRead)
        overrangeFlag <= 1'h0;
    end
  end

  // error channel latch; first error after a clear owns the field
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      errLatched <= 1'h0;
      errorSourceChannel <= sccds_pkg::CHAN_RESET;
    end
    else if (errEvent && (!errLatched || latchClear))
    begin
      errLatched <= 1'h1;
      errorSourceChannel <= errChannel;
    end
    else if (latchClear)
      errLatched <= 1'h0;
    // otherwise the held index is left alone
  end

  // pin is low while either routed flag stands; a flop keeps it glitch free
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      interruptOutN <= 1'h1;
    else
      interruptOutN <= !(underrangeFlag || overrangeFlag);
  end

  // read data; status shows the value from before its own clear
  always_comb
  begin
    next_rdData = 16'h0000;
    if (regAddr == sccds_pkg::ADDR_CH2_DIV)
      next_rdData = divValue[0];
    else if (regAddr == sccds_pkg::ADDR_CH3_DIV)
      next_rdData = divValue[1];
    else if (regAddr == sccds_pkg::ADDR_STATUS)
    begin
      next_rdData[sccds_pkg::ST_CHAN_MSB:sccds_pkg::ST_CHAN_LSB] =
        errorSourceChannel;
      next_rdData[sccds_pkg::ST_UR_BIT] = underrangeFlag;
      next_rdData[sccds_pkg::ST_OR_BIT] = overrangeFlag;
    end
    else if (regAddr == sccds_pkg::ADDR_ERR_CFG)
    begin
      next_rdData[sccds_pkg::CFG_UR_IRQ_BIT] = underrangeIrqEnable;
      next_rdData[sccds_pkg::CFG_OR_IRQ_BIT] = overrangeIrqEnable;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regRdData <= 16'h0000;
      regRdValid <= 1'h0;
    end
    else
    begin
      regRdValid <= regRd;
      if (regRd)
        regRdData <= next_rdData;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_ur_sets: assert property (urErr && underrangeIrqEnable |=>
    underrangeFlag)
    else $error("under-range flag not set");
  a_or_sets: assert property (orErr && overrangeIrqEnable |=>
    overrangeFlag)
    else $error("over-range flag not set");
  a_ur_gated: assert property ($rose(underrangeFlag) |->
    $past(urErr) && $past(underrangeIrqEnable))
    else $error("under-range flag set while not routed");
  a_or_gated: assert property ($rose(overrangeFlag) |->
    $past(orErr) && $past(overrangeIrqEnable))
    else $error("over-range flag set while not routed");
  a_status_clears: assert property (statusRead && !urEvent && !orEvent
    |=> !underrangeFlag && !overrangeFlag)
    else $error("status read left error flags set");
  a_latch_holds: assert property (errLatched && !latchClear |=>
    errLatched)
    else $error("error latch dropped without a read");
  a_chan_held: assert property (errLatched && !latchClear |=>
    $stable(errorSourceChannel))
    else $error("latched error channel overwritten");
  a_chan_capture: assert property (errEvent && (!errLatched || latchClear)
    |=> errorSourceChannel == $past(errChannel))
    else $error("error channel not captured");
  a_pin_follows: assert property ((underrangeFlag || overrangeFlag) |=>
    !interruptOutN)
    else $error("interrupt pin not asserted");
  a_rd_status: assert property (statusRead |=> regRdValid &&
    regRdData[13] == $past(underrangeFlag))
    else $error("status read data wrong");

  c_ur_report: cover property (urEvent ##1 statusRead ##1 regRdValid);
  c_data_clear: cover property (errLatched && !statusRead && latchClear);
  c_set_and_clear: cover property (urEvent && statusRead);
  c_both_flags: cover property (underrangeFlag && overrangeFlag);
endmodule : sccds_regs

// file: verif/sccds_host_model.sv
// Purpose: host side of the register port of the divider and status bank
// Assumes: strobes change at the falling clock edge only
// Notes: idle address and data lines are inverted so stale values never help
`timescale 1ns/10ps
module sccds_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] regAddr,
  output logic regWr,
  output logic regRd,
  output logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid
);
  // port idle from time zero
  initial
  begin
    regAddr = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    regWrData = 16'h0000;
  end
  // divider word as a careful host builds it
  function automatic logic [15:0] divWord(input logic [3:0] s,
    input logic [9:0] r);
    logic [3:0] q;
    q = (s < 4'h2) ? 4'h2 : s;
    return {q, 2'h0, r};
  endfunction : divWord
  // one write, strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'h1;
    @(negedge clk);
    regWr = 1'h0;
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask : wr
  // one read, answer taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
    output logic ok);
    @(negedge clk);
    regAddr = a;
    regRd = 1'h1;
    @(negedge clk);
    regRd = 1'h0;
    regAddr = ~regAddr;
    ok = regRdValid;
    d = regRdData;
  endtask : rd
endmodule : sccds_host_model

// file: verif/testbench.sv
// Purpose: self-checking bench of the divider and status bank
// Assumes: host model drives the register port, bench drives events
// Notes: random divider values come from a fixed xorshift seed
`timescale 1ns/10ps
module testbench;
  logic clk, arst_n, urErr, orErr, rdOk, u;
  logic [1:0] errChannel, sensorCfgBad, refTick, errorSourceChannel, c, pc;
  logic [7:0] regAddr;
  logic regWr, regRd, regRdValid, underrangeFlag, overrangeFlag;
  logic interruptOutN;
  logic [15:0] regWrData, regRdData, rdVal, w;
  logic [3:0] sensorInDivC2, sensorInDivC3;
  logic [9:0] refClkDivC2, refClkDivC3;
  logic [31:0] rng;
  int errorCnt, testsRun, n;
  logic [3:0] seenSens;
  logic [9:0] seenRef;
  logic seenFlag;
  // short names of the bank addresses and divider reset word keep the check lines narrow
  localparam logic [7:0] A_C2 = sccds_pkg::ADDR_CH2_DIV;
  localparam logic [7:0] A_C3 = sccds_pkg::ADDR_CH3_DIV;
  localparam logic [7:0] A_ST = sccds_pkg::ADDR_STATUS;
  localparam logic [7:0] A_CFG = sccds_pkg::ADDR_ERR_CFG;
  localparam logic [15:0] D_RST = sccds_pkg::DIV_RESET;
  // design and its host
  sccds_regs sccds_regs_i (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid), .urErr(urErr),
    .orErr(orErr), .errChannel(errChannel), .sensorInDivC2(sensorInDivC2),
    .sensorInDivC3(sensorInDivC3), .refClkDivC2(refClkDivC2),
    .refClkDivC3(refClkDivC3), .sensorCfgBad(sensorCfgBad),
    .refTick(refTick), .errorSourceChannel(errorSourceChannel),
    .underrangeFlag(underrangeFlag), .overrangeFlag(overrangeFlag),
    .interruptOutN(interruptOutN));
  sccds_host_model sccds_host_model_i (.clk(clk), .regAddr(regAddr),
    .regWr(regWr), .regRd(regRd), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid));
  // 50 ns clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // xorshift source
  function automatic logic [31:0] nextRand();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : nextRand
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, exp);
    testsRun++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tallyAndFinish
  // status word the rules predict; lower bits belong to other logic
  function automatic logic [15:0] statusExp(input logic [1:0] ch,
    input logic ur, input logic ov);
    return {ch, ur, ov, 12'h000};
  endfunction : statusExp
  // read with masked compare of the answer
  task automatic rdChk(input logic [7:0] a, input logic [15:0] m, exp);
    sccds_host_model_i.rd(a, rdVal, rdOk);
    check("rdValid", 16'(rdOk), 16'h0001);
    check("rdData", rdVal & m, exp);
  endtask : rdChk
  // bounded wait for the next reference tick
  task automatic waitTick(input int idx, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge clk);
      cnt++;
    end while (refTick[idx] !== 1'h1 && cnt < 40);
    if (cnt >= 40)
    begin
      errorCnt++;
      tallyAndFinish();
    end
  endtask : waitTick
  // one-cycle event pulse, channel lines moved on afterwards
  task automatic evt(input logic isUr, input logic [1:0] ch);
    @(negedge clk);
    urErr = isUr;
    orErr = ~isUr;
    errChannel = ch;
    @(negedge clk);
    urErr = 1'h0;
    orErr = 1'h0;
    errChannel = ~ch;
  endtask : evt
  // main sequence
  initial
  begin
    rng = 32'h0000001F;
    errorCnt = 0;
    testsRun = 0;
    pc = 2'h0;
    arst_n = 1'h0;
    urErr = 1'h0;
    orErr = 1'h0;
    errChannel = 2'h0;
    // six full clock periods in reset, released off the sampling edge
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1'h1;
    check("cfgBadRst", 16'(sensorCfgBad), 16'h0003);
    check("intRst", 16'(interruptOutN), 16'h0001);
    rdChk(A_C2, 16'hFFFF, D_RST);
    rdChk(A_C3, 16'hFFFF, D_RST);
    rdChk(A_ST, 16'hF000, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      w = sccds_host_model_i.divWord(4'(nextRand()),
        10'(nextRand() % 8 + 1));
      sccds_host_model_i.wr(i[0] ? A_C3 : A_C2, w);
      seenSens = i[0] ? sensorInDivC3 : sensorInDivC2;
      seenRef = i[0] ? refClkDivC3 : refClkDivC2;
      check("sensDiv", 16'(seenSens), 16'(w[15:12]));
      check("refDiv", 16'(seenRef), 16'(w[9:0]));
      check("cfgBad", 16'(sensorCfgBad[i[0]]), 16'h0000);
      rdChk(i[0] ? A_C3 : A_C2, 16'hFFFF, w);
      waitTick(i[0], n);
      waitTick(i[0], n);
      check("tickGap", 16'(n), 16'(w[9:0]));
    end
    sccds_host_model_i.wr(A_C3, 16'h0000);
    check("cfgBadZero", 16'(sensorCfgBad[1]), 16'h0001);
    repeat (12)
    begin
      @(negedge clk);
      check("tickIdle", 16'(refTick[1]), 16'h0000);
    end
    rdChk(8'h1A, 16'hFFFF, 16'h0000);
    sccds_host_model_i.wr(A_CFG, 16'hFFFF);
    rdChk(A_CFG, 16'hFFFF, 16'h00C0);
    $display("divider test done");
    for (int k = 0; k < 8; k++)
    begin
      c = k[1:0];
      u = ~k[2];
      sccds_host_model_i.wr(A_CFG, u ? 16'h0080 : 16'h0040);
      // the masked event of the last pass must have left no trace
      rdChk(A_ST, 16'hF000, statusExp(pc, 1'h0, 1'h0));
      evt(u, c);
      seenFlag = u ? underrangeFlag : overrangeFlag;
      check("flagSet", 16'(seenFlag), 16'h0001);
      check("chan", 16'(errorSourceChannel), 16'(c));
      @(negedge clk);
      check("intLow", 16'(interruptOutN), 16'h0000);
      evt(u, c ^ 2'h1);
      check("chanHeld", 16'(errorSourceChannel), 16'(c));
      sccds_host_model_i.rd({5'h00, c, 1'h0}, rdVal, rdOk);
      evt(u, c ^ 2'h2);
      pc = c ^ 2'h2;
      check("chanNew", 16'(errorSourceChannel), 16'(pc));
      rdChk(A_ST, 16'hF000, statusExp(pc, u, ~u));
      seenFlag = underrangeFlag | overrangeFlag;
      check("flagClr", 16'(seenFlag), 16'h0000);
      @(negedge clk);
      check("intHigh", 16'(interruptOutN), 16'h0001);
      sccds_host_model_i.wr(A_CFG, u ? 16'h0040 : 16'h0080);
      evt(u, c);
      seenFlag = underrangeFlag | overrangeFlag;
      check("masked", 16'(seenFlag), 16'h0000);
      check("chanKept", 16'(errorSourceChannel), 16'(pc));
    end
    $display("error test done");
    // event and status read on one edge: the new error must survive
    sccds_host_model_i.wr(A_CFG, 16'h0080);
    fork
      evt(1'h1, 2'h2);
      sccds_host_model_i.rd(A_ST, rdVal, rdOk);
    join
    w = statusExp(pc, 1'h0, 1'h0);
    check("rdSameOk", 16'(rdOk), 16'h0001);
    check("rdSame", rdVal & 16'hF000, w);
    check("setWins", 16'(underrangeFlag), 16'h0001);
    check("chanRecap", 16'(errorSourceChannel), 16'h0002);
    rdChk(A_ST, 16'hF000, statusExp(2'h2, 1'h1, 1'h0));
    check("flagGone", 16'(underrangeFlag), 16'h0000);
    $display("collision test done");
    tallyAndFinish();
  end
endmodule : testbench
